// ===== design/lane_sync_defines.vh
// named constants for the serdes lane sync and word mux block
`ifndef LANE_SYNC_DEFINES_VH
`define LANE_SYNC_DEFINES_VH

`define CHAR_W             10
`define COMMA_LEN          7
`define COMMA_POS          7'h7C
`define COMMA_NEG          7'h03
`define K28_1              8'h3C
`define K28_5              8'hBC
`define K28_7              8'hFC
`define IDLE_B1            8'h95
`define IDLE_B2            8'hB5
`define IDLE_B3            8'hB5
`define FC_IDLE_NEEDED     2'h3
`define FC_BAD_LIMIT       3'h4
`define XA_COMMA_NEEDED    2'h3
`define XA_GOOD_NEEDED     2'h3
`define XA_BAD_LIMIT       3'h4
`define COMMA_TIMEOUT      32'h00001000
`define ST_FAIL            2'h0
`define ST_OK              2'h1
`define ST_OK_NOC          2'h2
`define SLOT_LAST          2'h3
`define PHASE_INIT         8'hE4

`define ADDR_CTRL          4'h0
`define ADDR_STATUS        4'h4
`define CTRL_RESET         6'h00
`define CTRL_ALIGN_BIT     0
`define CTRL_REALIGN_BIT   1
`define CTRL_DECODE_BIT    2
`define CTRL_SEL_LSB       4
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== design/serdes_lane_sync_and_word_mux.v
// lane comma alignment, link sync machines, tx 4:1 mux and rx 1:4 demux
`timescale 1ns/100ps
`default_nettype none
`include "lane_sync_defines.vh"

module serdes_lane_sync_and_word_mux #(
    parameter [31:0] COMMA_TIMEOUT_CYC = `COMMA_TIMEOUT
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [9:0]  serdes_rx_raw,
    output reg  [9:0]  aligned_char,
    output reg         aligned_comma_flag,
    input  wire [9:0]  serdes_rx_char,
    input  wire        rx_code_err,
    output reg         link_word_sync,
    output reg  [1:0]  xaui_sync_status,
    output reg         sync_complete,
    output reg  [31:0] rx_fabric_word,
    output reg  [3:0]  rx_special_char_flags,
    output reg  [3:0]  rx_bit_nine_flags,
    output reg  [3:0]  rx_slot_comma_flags,
    output reg         rx_word_valid,
    input  wire [31:0] tx_fabric_word,
    input  wire [3:0]  tx_byte_ctrl,
    output reg         tx_word_taken,
    output reg  [8:0]  serdes_tx_char,
    output reg         tx_return_clock
);

    function is_comma_char;
        input [9:0] c;
        begin
            is_comma_char = c[8] && (c[7:0] == `K28_1 || c[7:0] == `K28_5
                                     || c[7:0] == `K28_7);
        end
    endfunction

    function is_comma_bits;
        input [6:0] b;
        begin
            is_comma_bits = (b == `COMMA_POS) || (b == `COMMA_NEG);
        end
    endfunction

    function [7:0] idle_byte;
        input [1:0] pos;
        begin
            if (pos == 2'h1) begin
                idle_byte = `IDLE_B1;
            end else if (pos == 2'h2) begin
                idle_byte = `IDLE_B2;
            end else begin
                idle_byte = `IDLE_B3;
            end
        end
    endfunction

    // register bus
    reg  [5:0]  ctrl_reg;
    reg  [3:0]  awaddr_reg;
    reg         aw_held_reg;
    reg  [31:0] wdata_reg;
    reg         w_held_reg;
    reg         wstb_reg;
    wire        align_en   = ctrl_reg[`CTRL_ALIGN_BIT];
    wire        realign_en = ctrl_reg[`CTRL_REALIGN_BIT];
    wire        decode_en  = ctrl_reg[`CTRL_DECODE_BIT];
    wire [1:0]  clk_sel    = ctrl_reg[`CTRL_SEL_LSB+1:`CTRL_SEL_LSB];
    wire        aw_ok      = aw_held_reg | (s_axi_awvalid & s_axi_awready);
    wire        w_ok       = w_held_reg | (s_axi_wvalid & s_axi_wready);
    wire [3:0]  wr_addr    = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data    = w_held_reg ? wdata_reg : s_axi_wdata;
    wire        wr_fire    = aw_ok & w_ok & ~s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg      <= `CTRL_RESET;
            awaddr_reg    <= 4'h0;
            aw_held_reg   <= 1'b0;
            wdata_reg     <= 32'h00000000;
            w_held_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_ok & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= ~w_ok & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wdata_reg <= s_axi_wdata;
                wstb_reg  <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_addr == `ADDR_CTRL) begin
                    if (w_held_reg ? wstb_reg : s_axi_wstrb[0]) begin
                        ctrl_reg <= wr_data[5:0];
                    end
                    s_axi_bresp <= `RESP_OKAY;
                end else if (wr_addr == `ADDR_STATUS) begin
                    s_axi_bresp <= `RESP_OKAY;
                end else begin
                    s_axi_bresp <= `RESP_SLVERR;
                end
            end else begin
                aw_held_reg <= aw_ok;
                w_held_reg  <= w_ok;
                if (s_axi_bvalid & s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                if (s_axi_araddr == `ADDR_CTRL) begin
                    s_axi_rdata <= {26'h0000000, ctrl_reg};
                    s_axi_rresp <= `RESP_OKAY;
                end else if (s_axi_araddr == `ADDR_STATUS) begin
                    s_axi_rdata <= {27'h0000000, sync_complete, xaui_sync_status,
                                    aligned_comma_flag, link_word_sync};
                    s_axi_rresp <= `RESP_OKAY;
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // comma byte alignment
    reg  [9:0]  raw_d_reg;
    reg  [3:0]  shift_reg;
    reg  [3:0]  shift_next;
    wire [19:0] hist = {serdes_rx_raw, raw_d_reg};
    wire [9:0]  hit;
    wire [9:0]  aligned_next = hist[shift_next +: 10];
    integer k;

    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1) begin : gen_hit
            assign hit[g] = is_comma_bits(hist[g +: `COMMA_LEN]);
        end
    endgenerate

    always @* begin
        shift_next = shift_reg;
        if (align_en && realign_en) begin
            for (k = 9; k >= 0; k = k - 1) begin
                if (hit[k]) begin
                    shift_next = k[3:0];
                end
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            raw_d_reg          <= 10'h000;
            shift_reg          <= 4'h0;
            aligned_char       <= 10'h000;
            aligned_comma_flag <= 1'b0;
        end else begin
            raw_d_reg          <= serdes_rx_raw;
            shift_reg          <= shift_next;
            aligned_char       <= aligned_next;
            aligned_comma_flag <= align_en & is_comma_bits(aligned_next[6:0]);
        end
    end

    // fibre-channel link machine
    localparam FC_LOS  = 1'b0;
    localparam FC_SYNC = 1'b1;
    reg        fc_state_reg;
    reg  [1:0] fc_pos_reg;
    reg  [1:0] fc_idles_reg;
    reg  [2:0] fc_bad_reg;
    reg        fc_good_reg;
    wire       rx_comma  = is_comma_char(serdes_rx_char) & decode_en;
    wire       rx_is_k   = serdes_rx_char[8] & decode_en;

    always @(posedge aclk) begin
        if (!aresetn || !decode_en) begin
            fc_state_reg   <= FC_LOS;
            fc_pos_reg     <= 2'h0;
            fc_idles_reg   <= 2'h0;
            fc_bad_reg     <= 3'h0;
            fc_good_reg    <= 1'b0;
            link_word_sync <= 1'b0;
        end else begin
            case (fc_state_reg)
                FC_LOS: begin
                    if (rx_code_err || (rx_comma && fc_pos_reg != 2'h0)) begin
                        fc_pos_reg   <= 2'h0;
                        fc_idles_reg <= 2'h0;
                    end else if (rx_comma) begin
                        fc_pos_reg <= 2'h1;
                    end else if (fc_pos_reg != 2'h0) begin
                        if (rx_is_k || serdes_rx_char[7:0] != idle_byte(fc_pos_reg)) begin
                            fc_pos_reg   <= 2'h0;
                            fc_idles_reg <= 2'h0;
                        end else if (fc_pos_reg == `SLOT_LAST) begin
                            fc_pos_reg <= 2'h0;
                            if (fc_idles_reg == `FC_IDLE_NEEDED - 2'h1) begin
                                fc_state_reg   <= FC_SYNC;
                                link_word_sync <= 1'b1;
                                fc_idles_reg   <= 2'h0;
                                fc_bad_reg     <= 3'h0;
                                fc_good_reg    <= 1'b0;
                            end else begin
                                fc_idles_reg <= fc_idles_reg + 2'h1;
                            end
                        end else begin
                            fc_pos_reg <= fc_pos_reg + 2'h1;
                        end
                    end
                end
                default: begin
                    if (rx_code_err) begin
                        fc_good_reg <= 1'b0;
                        if (fc_bad_reg == `FC_BAD_LIMIT - 3'h1) begin
                            fc_state_reg   <= FC_LOS;
                            link_word_sync <= 1'b0;
                            fc_bad_reg     <= 3'h0;
                        end else begin
                            fc_bad_reg <= fc_bad_reg + 3'h1;
                        end
                    end else if (fc_bad_reg != 3'h0) begin
                        fc_good_reg <= ~fc_good_reg;
                        if (fc_good_reg) begin
                            fc_bad_reg <= fc_bad_reg - 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // xaui lane sync machine
    localparam XA_FAIL = 1'b0;
    localparam XA_SYNC = 1'b1;
    reg        xa_state_reg;
    reg  [1:0] xa_commas_reg;
    reg  [2:0] xa_bad_reg;
    reg  [1:0] good_group_count;
    reg  [31:0] comma_timer_reg;
    wire       no_comma = (comma_timer_reg >= COMMA_TIMEOUT_CYC - 32'h1);

    always @(posedge aclk) begin
        if (!aresetn || !decode_en) begin
            xa_state_reg     <= XA_FAIL;
            xa_commas_reg    <= 2'h0;
            xa_bad_reg       <= 3'h0;
            good_group_count <= 2'h0;
            comma_timer_reg  <= 32'h0;
            sync_complete    <= 1'b0;
            xaui_sync_status <= `ST_FAIL;
        end else begin
            if (rx_comma && !rx_code_err) begin
                comma_timer_reg <= 32'h0;
            end else if (!no_comma) begin
                comma_timer_reg <= comma_timer_reg + 32'h1;
            end
            case (xa_state_reg)
                XA_FAIL: begin
                    xaui_sync_status <= `ST_FAIL;
                    sync_complete    <= 1'b0;
                    if (rx_code_err) begin
                        xa_commas_reg <= 2'h0;
                    end else if (rx_comma) begin
                        if (xa_commas_reg == `XA_COMMA_NEEDED - 2'h1) begin
                            xa_state_reg     <= XA_SYNC;
                            xa_commas_reg    <= 2'h0;
                            xa_bad_reg       <= 3'h0;
                            good_group_count <= 2'h0;
                            sync_complete    <= 1'b1;
                            xaui_sync_status <= `ST_OK;
                        end else begin
                            xa_commas_reg <= xa_commas_reg + 2'h1;
                        end
                    end
                end
                default: begin
                    xaui_sync_status <= no_comma ? `ST_OK_NOC : `ST_OK;
                    if (rx_code_err) begin
                        good_group_count <= 2'h0;
                        if (xa_bad_reg == `XA_BAD_LIMIT - 3'h1) begin
                            xa_state_reg     <= XA_FAIL;
                            sync_complete    <= 1'b0;
                            xaui_sync_status <= `ST_FAIL;
                            xa_bad_reg       <= 3'h0;
                        end else begin
                            xa_bad_reg <= xa_bad_reg + 3'h1;
                        end
                    end else if (xa_bad_reg != 3'h0) begin
                        if (good_group_count == `XA_GOOD_NEEDED - 2'h1) begin
                            good_group_count <= 2'h0;
                            xa_bad_reg       <= xa_bad_reg - 3'h1;
                        end else begin
                            good_group_count <= good_group_count + 2'h1;
                        end
                    end
                end
            endcase
        end
    end

    // receive 1:4 demux
    reg  [1:0]  rx_slot_reg;
    reg  [31:0] rx_acc_reg;
    reg  [3:0]  rx_b8_reg;
    reg  [3:0]  rx_b9_reg;
    reg  [3:0]  rx_cm_reg;
    wire        link_sync = link_word_sync | sync_complete;
    wire        restart   = link_sync & rx_comma & (rx_slot_reg != 2'h0);
    wire [1:0]  slot      = restart ? 2'h0 : rx_slot_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_slot_reg           <= 2'h0;
            rx_acc_reg            <= 32'h00000000;
            rx_b8_reg             <= 4'h0;
            rx_b9_reg             <= 4'h0;
            rx_cm_reg             <= 4'h0;
            rx_fabric_word        <= 32'h00000000;
            rx_special_char_flags <= 4'h0;
            rx_bit_nine_flags     <= 4'h0;
            rx_slot_comma_flags   <= 4'h0;
            rx_word_valid         <= 1'b0;
        end else begin
            rx_slot_reg <= slot + 2'h1;
            rx_acc_reg[slot*8 +: 8] <= serdes_rx_char[7:0];
            rx_b8_reg[slot] <= serdes_rx_char[8];
            rx_b9_reg[slot] <= serdes_rx_char[9];
            rx_cm_reg[slot] <= rx_comma & link_sync;
            rx_word_valid <= (slot == `SLOT_LAST);
            if (slot == `SLOT_LAST) begin
                rx_fabric_word        <= {serdes_rx_char[7:0], rx_acc_reg[23:0]};
                rx_special_char_flags <= {serdes_rx_char[8], rx_b8_reg[2:0]};
                rx_bit_nine_flags     <= {serdes_rx_char[9], rx_b9_reg[2:0]};
                rx_slot_comma_flags   <= {rx_comma & link_sync, rx_cm_reg[2:0]};
            end
        end
    end

    // transmit 4:1 mux and returned clock
    reg  [1:0]  ch_phase_reg [0:3];
    reg  [31:0] tx_word_reg;
    reg  [3:0]  tx_ctrl_reg;
    wire [1:0]  sel_phase = ch_phase_reg[clk_sel];
    localparam [7:0] PH_INIT = `PHASE_INIT;

    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_div
            always @(posedge aclk) begin
                if (!aresetn) begin
                    ch_phase_reg[g] <= PH_INIT[2*g +: 2];
                end else begin
                    ch_phase_reg[g] <= ch_phase_reg[g] + 2'h1;
                end
            end
        end
    endgenerate

    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_word_reg     <= 32'h00000000;
            tx_ctrl_reg     <= 4'h0;
            tx_word_taken   <= 1'b0;
            serdes_tx_char  <= 9'h000;
            tx_return_clock <= 1'b0;
        end else begin
            tx_return_clock <= sel_phase[1];
            tx_word_taken   <= (sel_phase == `SLOT_LAST);
            if (sel_phase == `SLOT_LAST) begin
                tx_word_reg    <= tx_fabric_word;
                tx_ctrl_reg    <= tx_byte_ctrl;
                serdes_tx_char <= {tx_byte_ctrl[0], tx_fabric_word[7:0]};
            end else begin
                serdes_tx_char <= {tx_ctrl_reg[sel_phase + 2'h1],
                                   tx_word_reg[(sel_phase + 2'h1)*8 +: 8]};
            end
        end
    end

endmodule
`default_nettype wire

// ===== dv/lane_sync_chk.sv
// port assertions for the lane sync and word mux block
`timescale 1ns/100ps
`default_nettype none
`include "lane_sync_defines.vh"
module lane_sync_chk (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic [9:0] aligned_char,
    input wire logic       aligned_comma_flag,
    input wire logic [9:0] serdes_rx_char,
    input wire logic       link_word_sync,
    input wire logic [1:0] xaui_sync_status,
    input wire logic       sync_complete,
    input wire logic [3:0] rx_slot_comma_flags,
    input wire logic       rx_word_valid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire        synced = link_word_sync || sync_complete;
    logic       prev_sync;
    logic [2:0] steady;
    // cycles for which the sync view has not changed, saturating at 7
    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_sync <= 1'b0;
            steady    <= 3'h0;
        end else begin
            prev_sync <= synced;
            if (synced != prev_sync)
                steady <= 3'h0;
            else if (steady != 3'h7)
                steady <= steady + 3'h1;
        end
    end
    comma_flag_a:
    assert property (aligned_comma_flag |->
        aligned_char[6:0] == `COMMA_POS || aligned_char[6:0] == `COMMA_NEG)
        else $error("comma flag on a char without aligned comma");
    status_code_a:
    assert property (xaui_sync_status != 2'h3) else $error("lane status code unused");
    fail_cplt_a:
    assert property (xaui_sync_status == `ST_FAIL && $past(xaui_sync_status) == `ST_FAIL
        |-> !sync_complete) else $error("sync complete while lane failed");
    cplt_rise_a:
    assert property ($rose(sync_complete) |-> $past(serdes_rx_char[8]) ||
        $past(serdes_rx_char[8], 2)) else $error("sync complete without comma");
    wsync_rise_a:
    assert property ($rose(link_word_sync) |-> $past(serdes_rx_char[7:0]) == `IDLE_B3 ||
        $past(serdes_rx_char[7:0], 2) == `IDLE_B3) else $error("word sync not at idle end");
    word_pulse_a:
    assert property (rx_word_valid |=> !rx_word_valid [*3]) else $error("words too close");
    nosync_flags_a:
    assert property (rx_word_valid && steady == 3'h7 && !synced |->
        rx_slot_comma_flags == 4'h0) else $error("comma flags without sync");
    comma_slot_a:
    assert property (rx_word_valid && steady == 3'h7 && synced |->
        rx_slot_comma_flags[3:1] == 3'h0) else $error("comma not in leading slot");
    cover property ($rose(link_word_sync));
    cover property (xaui_sync_status == `ST_OK_NOC);
    cover property (rx_word_valid && rx_slot_comma_flags[0]);
endmodule
bind serdes_lane_sync_and_word_mux lane_sync_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .aligned_char(aligned_char), .aligned_comma_flag(aligned_comma_flag),
    .serdes_rx_char(serdes_rx_char), .link_word_sync(link_word_sync),
    .xaui_sync_status(xaui_sync_status), .sync_complete(sync_complete),
    .rx_slot_comma_flags(rx_slot_comma_flags), .rx_word_valid(rx_word_valid));
`default_nettype wire

// ===== dv/fabric_tx_model.sv
// fabric-side transmit source offering a fresh word after each capture
`timescale 1ns/100ps
`default_nettype none
module fabric_tx_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        tx_word_taken,
    output var  logic [31:0] tx_fabric_word,
    output var  logic [3:0]  tx_byte_ctrl
);
    // word changes only right after a capture, so it is settled at every capture edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_fabric_word <= 32'h44332211;
            tx_byte_ctrl   <= 4'h5;
        end else if (tx_word_taken === 1'b1) begin
            tx_fabric_word <= tx_fabric_word + 32'h01030507;
            tx_byte_ctrl   <= {tx_byte_ctrl[2:0], tx_byte_ctrl[3]} ^ 4'h2;
        end
    end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the lane sync and word mux block
`timescale 1ns/100ps
`default_nettype none
`include "lane_sync_defines.vh"
module tb;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, aligned_comma_flag, rx_code_err, link_word_sync, sync_complete;
    logic        rx_word_valid, tx_word_taken, tx_return_clock;
    logic [1:0]  s_axi_bresp, s_axi_rresp, xaui_sync_status, rsp;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, tx_byte_ctrl;
    logic [3:0]  rx_special_char_flags, rx_bit_nine_flags, rx_slot_comma_flags;
    logic [8:0]  serdes_tx_char;
    logic [9:0]  serdes_rx_raw, aligned_char, serdes_rx_char;
    logic [31:0] s_axi_wdata, s_axi_rdata, rx_fabric_word, tx_fabric_word, rd;
    logic [43:0] cap;
    int          miscompares, checks, cyc, t1, t2, base, n;
    serdes_lane_sync_and_word_mux #(.COMMA_TIMEOUT_CYC(32'h10)) u_serdes_lane_sync_and_word_mux (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serdes_rx_raw, .aligned_char,
        .aligned_comma_flag, .serdes_rx_char, .rx_code_err, .link_word_sync,
        .xaui_sync_status, .sync_complete, .rx_fabric_word, .rx_special_char_flags,
        .rx_bit_nine_flags, .rx_slot_comma_flags, .rx_word_valid, .tx_fabric_word,
        .tx_byte_ctrl, .tx_word_taken, .serdes_tx_char, .tx_return_clock);
    fabric_tx_model u_fabric_tx_model (.aclk, .aresetn, .tx_word_taken, .tx_fabric_word,
        .tx_byte_ctrl);
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (rx_word_valid === 1'b1)
            cap <= {rx_slot_comma_flags, rx_bit_nine_flags, rx_special_char_flags, rx_fabric_word};
        if (cyc == 5000) begin
            miscompares++;
            close_out;
        end
    end
    task close_out;
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [43:0] seen, input logic [43:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (s_axi_bvalid !== 1'b1) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axr(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (s_axi_rvalid !== 1'b1) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        rd  = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task rxc(input logic [9:0] c, input logic e);
        @(posedge aclk);
        serdes_rx_char <= c;
        rx_code_err    <= e;
    endtask
    task idle(input int k);
        repeat (k) begin
            rxc({2'b01, `K28_5}, 1'b0);
            rxc({2'b00, `IDLE_B1}, 1'b0);
            rxc({2'b00, `IDLE_B2}, 1'b0);
            rxc({2'b00, `IDLE_B3}, 1'b0);
        end
    endtask
    task settle;
        repeat (4) @(posedge aclk);
        #1;
    endtask
    task rise(output int t);
        logic p;
        p = 1'b1;
        t = 0;
        for (int i = 0; i < 10 && t == 0; i++) begin
            @(posedge aclk);
            #1;
            if (tx_return_clock === 1'b1 && p === 1'b0) t = cyc;
            p = tx_return_clock;
        end
    endtask
    task tx_check;
        logic [31:0] w;
        logic [3:0]  c;
        n = 0;
        while (tx_word_taken !== 1'b1 && n < 10) begin
            @(posedge aclk);
            #1 n++;
        end
        w = tx_fabric_word;
        c = tx_byte_ctrl;
        for (int i = 0; i < 4; i++) begin
            chk("tx_char", serdes_tx_char, {c[i], w[8*i +: 8]});
            @(posedge aclk);
            #1;
        end
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, serdes_rx_raw, serdes_rx_char} = '0;
        {rx_code_err, cyc, miscompares, checks, cap} = '0;
        s_axi_wstrb = 4'hF;
        @(posedge aclk);
        @(posedge aclk) aresetn <= 1'b1;
        #1 chk("reset_sync", {link_word_sync, xaui_sync_status, sync_complete}, 0);
        axr(`ADDR_CTRL);
        chk("ctrl_reset", rd, `CTRL_RESET);
        axr(4'h8);
        chk("unmapped", {rsp, rd}, {`RESP_SLVERR, 32'h0});
        axw(`ADDR_CTRL, 32'h7);
        chk("bresp", rsp, `RESP_OKAY);
        axr(`ADDR_CTRL);
        chk("ctrl_rd", {rsp, rd}, {`RESP_OKAY, 32'h7});
        for (int i = 0; i < 2; i++) begin
            @(posedge aclk) serdes_rx_raw <= i ? 10'h22F : 10'h17C;
            repeat (5) @(posedge aclk);
            #1 chk("aligned", {aligned_comma_flag, aligned_char}, 11'h57C);
        end
        idle(2);
        rxc(10'h000, 1'b1);
        idle(2);
        settle;
        chk("restart", {link_word_sync, xaui_sync_status}, 0);
        idle(1);
        settle;
        chk("acquire", {link_word_sync, xaui_sync_status, sync_complete}, 4'b1011);
        repeat (6) begin
            rxc(10'h000, 1'b1);
            rxc(10'h1BC, 1'b0);
            rxc(10'h1BC, 1'b0);
        end
        rxc(10'h055, 1'b0);
        settle;
        chk("hyst", {link_word_sync, xaui_sync_status, sync_complete}, 4'b1000);
        idle(3);
        repeat (3) rxc(10'h000, 1'b1);
        rxc(10'h055, 1'b0);
        rxc(10'h000, 1'b1);
        #1 chk("three_bad", link_word_sync, 1);
        rxc(10'h055, 1'b0);
        n = 0;
        while (link_word_sync !== 1'b0 && n < 8) begin
            @(posedge aclk);
            #1 n++;
        end
        chk("four_bad", link_word_sync, 0);
        idle(3);
        settle;
        rxc(10'h055, 1'b0);
        n = 0;
        while (xaui_sync_status !== `ST_OK_NOC && n < 40) begin
            @(posedge aclk);
            #1 n++;
        end
        chk("no_comma", {xaui_sync_status, (n > 4 && n < 20)}, {`ST_OK_NOC, 1'b1});
        rxc(10'h1BC, 1'b0);
        settle;
        chk("comma_back", xaui_sync_status, `ST_OK);
        rxc(10'h055, 1'b0);
        rxc(10'h1BC, 1'b0);
        rxc(10'h011, 1'b0);
        rxc(10'h222, 1'b0);
        rxc(10'h133, 1'b0);
        settle;
        chk("demux", cap, {4'h1, 4'h4, 4'h9, 32'h332211BC});
        for (int s = 0; s < 4; s++) begin
            axw(`ADDR_CTRL, 32'h7 | (s << `CTRL_SEL_LSB));
            rise(t1);
            rise(t2);
            if (s == 0) base = t1 % 4;
            chk("ret_period", t2 - t1, 4);
            chk("ret_select", (t1 + s) % 4, base);
            tx_check;
        end
        close_out;
    end
endmodule
`default_nettype wire
